// >>> logic/bnkrf_pkg.sv
// constants for the banked register file and status words
// assumes one core clock and a synchronous active-high reset
// Notes on behaviour
// - compact state reaches r0-r7, pc, sp, lr and the current word directly
// - each privileged mode except system banks its own sp, lr and saved word by mode field
// - exactly one current status word and five saved words exist
// - compact state reaches r8-r12 only through special move, compare, add forms
// - unused status bits read back and write as stored
// - flags follow alu results, status writes and load-multiple
// - word state conditions every op; compact state conditions only branches
// - saturation flag sticks until a status write or an exception return clears it; never a condition
// - low eight bits hold masks, state bit and mode field
// - control bits change on exceptions; only privileged writes change them, except the state bit, which t_we sets in any mode
// - normal interrupt ignored while its mask bit is one
// - fast interrupt ignored while its mask bit is one
// - state bit is one in compact state, zero in word state
// - state bit drives the state indicator pin continuously
// - user 10000 and system 11111 use unbanked r0-r14, no saved word
// - mode 10001 banks r8-r14 and has its own saved word
// - mode 10010 banks r13, r14 and has its own saved word
// - modes 10011, 10111, 11011 bank r13, r14 and a saved word
// - an undefined mode code may wedge the core until reset
// - processor state is kept before a handler starts
// - simultaneous exceptions are taken in one fixed priority
// - exception entry copies current word into the target saved word
// - reset gives supervisor mode, both masks set, state bit clear
package bnkrf_pkg;
   localparam logic [7:0] OFF_CSW = 8'h00;
   localparam logic [7:0] OFF_SSW = 8'h04;
   localparam int BIT_N = 31;
   localparam int BIT_Z = 30;
   localparam int BIT_C = 29;
   localparam int BIT_V = 28;
   localparam int BIT_Q = 27;
   localparam int BIT_I = 7;
   localparam int BIT_F = 6;
   localparam int BIT_T = 5;
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1B;
   localparam logic [4:0] MODE_SYS = 5'h1F;
   localparam logic [31:0] CSW_RST = 32'h0000_00D3;
   localparam int NUM_SSW = 5;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   // exception request bit positions, highest priority first
   localparam int EXC_DABT = 0;
   localparam int EXC_FIQ = 1;
   localparam int EXC_IRQ = 2;
   localparam int EXC_PABT = 3;
   localparam int EXC_UND = 4;
   localparam int EXC_SWI = 5;
   localparam int NUM_EXC = 6;
   localparam int NUM_PHYS = 31;
   localparam logic [4:0] IDX_PC = 5'h0F;
endpackage : bnkrf_pkg

// >>> logic/bnkrf_psr_if.sv
// status word carrier between the register file top and the status unit
// assumes both ends run on the same core clock
interface bnkrf_psr_if;
   logic [31:0] current_status_word;
   logic [31:0] saved_status_word_cur;
   logic saved_status_word_ok;
   logic flag_we;
   logic [3:0] flag_val;
   logic q_set;
   logic psr_we;
   logic psr_saved_status_word;
   logic [3:0] psr_mask;
   logic [31:0] psr_data;
   logic [5:0] exc_req;
   logic exc_ret;
   logic t_we;
   logic t_val;
   logic exc_taken;
   logic [4:0] exc_mode;
   modport unit (output current_status_word, saved_status_word_cur, saved_status_word_ok, exc_taken, exc_mode,
      input flag_we, flag_val, q_set, psr_we, psr_saved_status_word, psr_mask, psr_data,
      exc_req, exc_ret, t_we, t_val);
   modport core (input current_status_word, saved_status_word_cur, saved_status_word_ok, exc_taken, exc_mode,
      output flag_we, flag_val, q_set, psr_we, psr_saved_status_word, psr_mask, psr_data,
      exc_req, exc_ret, t_we, t_val);
endinterface : bnkrf_psr_if

// >>> logic/bnkrf_psr.sv
// current status word, five saved words and exception entry
// assumes requests arrive synchronous to clk from the core top
module bnkrf_psr (
   input wire logic clk,
   input wire logic sys_rst,
   bnkrf_psr_if.unit pif
);
   logic [31:0] current_status_word_r;
   logic [31:0] current_status_word_nxt;
   logic [31:0] saved_status_word_r [0:bnkrf_pkg::NUM_SSW-1];
   logic [5:0] req_live;
   logic [4:0] tgt_mode;
   logic hit;

   // saved word slot of a mode, none for user and system
   function automatic logic [2:0] slot_of(input logic [4:0] m);
      case (m)
         bnkrf_pkg::MODE_FIQ: slot_of = 3'h0;
         bnkrf_pkg::MODE_IRQ: slot_of = 3'h1;
         bnkrf_pkg::MODE_SVC: slot_of = 3'h2;
         bnkrf_pkg::MODE_ABT: slot_of = 3'h3;
         bnkrf_pkg::MODE_UND: slot_of = 3'h4;
         default: slot_of = bnkrf_pkg::SLOT_NONE;
      endcase
   endfunction : slot_of

   // byte-lane merge for status writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
         input logic [3:0] m);
      merge = o;
      for (int b = 0; b < 4; b++) begin
         if (m[b]) begin
            merge[8*b +: 8] = n[8*b +: 8];
         end
      end
   endfunction : merge

   wire logic [2:0] cur_slot = slot_of(current_status_word_r[4:0]);
   wire logic priv = current_status_word_r[4:0] != bnkrf_pkg::MODE_USR;
   wire logic [3:0] csw_mask = {pif.psr_mask[3:1], pif.psr_mask[0] & priv};
   wire logic [2:0] tgt_slot = slot_of(tgt_mode);
   assign pif.saved_status_word_ok = cur_slot != bnkrf_pkg::SLOT_NONE;
   assign pif.saved_status_word_cur = pif.saved_status_word_ok ? saved_status_word_r[cur_slot] : 32'h0000_0000;
   assign pif.current_status_word = current_status_word_r;
   assign pif.exc_taken = hit;
   assign pif.exc_mode = tgt_mode;

   // masks gate interrupts, then the fixed order picks one
   always_comb begin
      req_live = pif.exc_req;
      req_live[bnkrf_pkg::EXC_FIQ] = pif.exc_req[bnkrf_pkg::EXC_FIQ]
         & ~current_status_word_r[bnkrf_pkg::BIT_F];
      req_live[bnkrf_pkg::EXC_IRQ] = pif.exc_req[bnkrf_pkg::EXC_IRQ]
         & ~current_status_word_r[bnkrf_pkg::BIT_I];
      hit = |req_live;
      if (req_live[bnkrf_pkg::EXC_DABT] || req_live[bnkrf_pkg::EXC_PABT]) begin
         tgt_mode = req_live[bnkrf_pkg::EXC_DABT] || !req_live[bnkrf_pkg::EXC_FIQ]
            && !req_live[bnkrf_pkg::EXC_IRQ] ? bnkrf_pkg::MODE_ABT
            : req_live[bnkrf_pkg::EXC_FIQ] ? bnkrf_pkg::MODE_FIQ : bnkrf_pkg::MODE_IRQ;
      end else if (req_live[bnkrf_pkg::EXC_FIQ]) begin
         tgt_mode = bnkrf_pkg::MODE_FIQ;
      end else if (req_live[bnkrf_pkg::EXC_IRQ]) begin
         tgt_mode = bnkrf_pkg::MODE_IRQ;
      end else if (req_live[bnkrf_pkg::EXC_UND]) begin
         tgt_mode = bnkrf_pkg::MODE_UND;
      end else begin
         tgt_mode = bnkrf_pkg::MODE_SVC;
      end
   end

   // next current word: entry, return, write, then flag updates
   always_comb begin
      current_status_word_nxt = current_status_word_r;
      if (hit) begin
         current_status_word_nxt[4:0] = tgt_mode;
         current_status_word_nxt[bnkrf_pkg::BIT_T] = 1'b0;
         current_status_word_nxt[bnkrf_pkg::BIT_I] = 1'b1;
         if (tgt_mode == bnkrf_pkg::MODE_FIQ) begin
            current_status_word_nxt[bnkrf_pkg::BIT_F] = 1'b1;
         end
      end else if (pif.exc_ret && pif.saved_status_word_ok) begin
         current_status_word_nxt = pif.saved_status_word_cur;
      end else if (pif.psr_we && !pif.psr_saved_status_word) begin
         current_status_word_nxt = merge(current_status_word_r, pif.psr_data, csw_mask);
      end else begin
         if (pif.t_we) begin
            current_status_word_nxt[bnkrf_pkg::BIT_T] = pif.t_val;
         end
         if (pif.flag_we) begin
            current_status_word_nxt[31:28] = pif.flag_val;
         end
      end
      if (pif.q_set) begin
         current_status_word_nxt[bnkrf_pkg::BIT_Q] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         current_status_word_r <= bnkrf_pkg::CSW_RST;
      end else begin
         current_status_word_r <= current_status_word_nxt;
      end
   end

   // saved words: entry copy wins over a status write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < bnkrf_pkg::NUM_SSW; i++) begin
            saved_status_word_r[i] <= 32'h0000_0000;
         end
      end else if (hit) begin
         saved_status_word_r[tgt_slot] <= current_status_word_r;
      end else if (pif.psr_we && pif.psr_saved_status_word && pif.saved_status_word_ok) begin
         saved_status_word_r[cur_slot] <= merge(saved_status_word_r[cur_slot], pif.psr_data, pif.psr_mask);
      end
   end

   a_entry_saves: assert property (@(posedge clk) disable iff (sys_rst)
      hit |=> saved_status_word_r[slot_of(current_status_word_r[4:0])] == $past(current_status_word_r))
      else $error("saved word not loaded on entry");
   a_q_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      current_status_word_r[bnkrf_pkg::BIT_Q] && !pif.psr_we && !hit && !pif.exc_ret
      |=> current_status_word_r[bnkrf_pkg::BIT_Q])
      else $error("saturation flag dropped");
   a_user_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
      pif.psr_we && !pif.psr_saved_status_word && !hit && !pif.exc_ret && !priv
      |=> current_status_word_r[7:0] == $past(current_status_word_r[7:0]))
      else $error("user write changed control bits");
   a_irq_mask: assert property (@(posedge clk) disable iff (sys_rst)
      current_status_word_r[bnkrf_pkg::BIT_I] && pif.exc_req == 6'h04 |-> !hit)
      else $error("masked normal interrupt taken");
   a_fiq_mask: assert property (@(posedge clk) disable iff (sys_rst)
      current_status_word_r[bnkrf_pkg::BIT_F] && pif.exc_req == 6'h02 |-> !hit)
      else $error("masked fast interrupt taken");
endmodule : bnkrf_psr

// >>> logic/bnkrf_top.sv
// banked general registers, status words and software register port
// assumes decode drives requests on clk; register port reads answer next cycle
module bnkrf_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [3:0] ra_addr,
   output logic [31:0] ra_data,
   input wire logic [3:0] rb_addr,
   output logic [31:0] rb_data,
   input wire logic rw_en,
   input wire logic [3:0] rw_addr,
   input wire logic [31:0] rw_data,
   input wire logic hi_ok,
   output logic access_err,
   output logic [31:0] pc_out,
   input wire logic flag_we,
   input wire logic [3:0] flag_val,
   input wire logic q_set,
   input wire logic status_write_op,
   input wire logic msr_saved_status_word,
   input wire logic [3:0] msr_mask,
   input wire logic [31:0] msr_data,
   input wire logic [5:0] exc_req,
   input wire logic exc_ret,
   input wire logic t_we,
   input wire logic t_val,
   input wire logic [3:0] cond,
   input wire logic is_branch,
   output logic cond_ok,
   output logic exc_taken,
   output logic [4:0] exc_mode,
   output logic [4:0] cur_mode,
   output logic irq_mask,
   output logic fiq_mask,
   output logic state_indicator_out,
   output logic [31:0] csw_out,
   output logic [31:0] ssw_out
);
   bnkrf_psr_if pif ();

   logic [31:0] gpr_r [0:bnkrf_pkg::NUM_PHYS-1];
   logic [31:0] reg_rdata_r;
   logic [31:0] reg_rdata_nxt;

   // physical slot of an architectural register in a given mode
   function automatic logic [4:0] phys_idx(input logic [3:0] a, input logic [4:0] m);
      logic [4:0] base;
      base = 5'h00;
      case (m)
         bnkrf_pkg::MODE_IRQ: base = 5'h17;
         bnkrf_pkg::MODE_SVC: base = 5'h19;
         bnkrf_pkg::MODE_ABT: base = 5'h1B;
         bnkrf_pkg::MODE_UND: base = 5'h1D;
         default: base = 5'h00;
      endcase
      if (m == bnkrf_pkg::MODE_FIQ && a >= 4'h8 && a <= 4'hE) begin
         phys_idx = 5'h10 + {1'b0, a} - 5'h08;
      end else if (base != 5'h00 && a >= 4'hD && a <= 4'hE) begin
         phys_idx = base + {1'b0, a} - 5'h0D;
      end else begin
         phys_idx = {1'b0, a};
      end
   endfunction : phys_idx

   // compact state hides r8-r12 unless the op is a high-register form
   function automatic logic hidden(input logic [3:0] a, input logic t, input logic h);
      hidden = t && !h && a >= 4'h8 && a <= 4'hC;
   endfunction : hidden

   // condition code test on n, z, c, v; saturation flag never enters
   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      logic r;
      n = f[3];
      z = f[2];
      cy = f[1];
      v = f[0];
      case (c[3:1])
         3'h0: r = z;
         3'h1: r = cy;
         3'h2: r = n;
         3'h3: r = v;
         3'h4: r = cy && !z;
         3'h5: r = n == v;
         3'h6: r = !z && n == v;
         default: r = 1'b1;
      endcase
      cond_pass = c == 4'hF ? 1'b0 : (c[0] && c[3:1] != 3'h7 ? !r : r);
   endfunction : cond_pass

   // current mode and state from the status unit
   wire logic [4:0] mode = pif.current_status_word[4:0];
   wire logic tstate = pif.current_status_word[bnkrf_pkg::BIT_T];
   wire logic [4:0] ra_phys = phys_idx(ra_addr, mode);
   wire logic [4:0] rb_phys = phys_idx(rb_addr, mode);
   wire logic [4:0] rw_phys = phys_idx(rw_addr, mode);
   wire logic ra_hide = hidden(ra_addr, tstate, hi_ok);
   wire logic rb_hide = hidden(rb_addr, tstate, hi_ok);
   wire logic rw_hide = rw_en && hidden(rw_addr, tstate, hi_ok);
   wire logic rw_ok = rw_en && !rw_hide;

   // register port decode
   wire logic bus_csw = reg_addr == bnkrf_pkg::OFF_CSW;
   wire logic bus_ssw = reg_addr == bnkrf_pkg::OFF_SSW;
   wire logic bus_psr_we = reg_wr && (bus_csw || bus_ssw);

   // core status writes take the port before software writes
   assign pif.flag_we = flag_we;
   assign pif.flag_val = flag_val;
   assign pif.q_set = q_set;
   assign pif.psr_we = status_write_op || bus_psr_we;
   assign pif.psr_saved_status_word = status_write_op ? msr_saved_status_word : bus_ssw;
   assign pif.psr_mask = status_write_op ? msr_mask : 4'hF;
   assign pif.psr_data = status_write_op ? msr_data : reg_wdata;
   assign pif.exc_req = exc_req;
   assign pif.exc_ret = exc_ret;
   assign pif.t_we = t_we;
   assign pif.t_val = t_val;

   bnkrf_psr u_psr (
      .clk(clk),
      .sys_rst(sys_rst),
      .pif(pif)
   );

   // combinational read ports off banked storage
   assign ra_data = ra_hide ? 32'h0000_0000 : gpr_r[ra_phys];
   assign rb_data = rb_hide ? 32'h0000_0000 : gpr_r[rb_phys];
   assign access_err = ra_hide || rb_hide || rw_hide;
   assign pc_out = gpr_r[bnkrf_pkg::IDX_PC];

   // compact state lets only branches be conditional
   assign cond_ok = tstate && !is_branch ? 1'b1 : cond_pass(cond, pif.current_status_word[31:28]);

   // status views
   assign csw_out = pif.current_status_word;
   assign ssw_out = pif.saved_status_word_cur;
   assign cur_mode = mode;
   assign irq_mask = pif.current_status_word[bnkrf_pkg::BIT_I];
   assign fiq_mask = pif.current_status_word[bnkrf_pkg::BIT_F];
   assign state_indicator_out = tstate;
   assign exc_taken = pif.exc_taken;
   assign exc_mode = pif.exc_mode;

   // register file write port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < bnkrf_pkg::NUM_PHYS; i++) begin
            gpr_r[i] <= 32'h0000_0000;
         end
      end else if (rw_ok) begin
         gpr_r[rw_phys] <= rw_data;
      end
   end

   // read answer for the register port
   assign reg_rdata_nxt = !reg_rd ? 32'h0000_0000
      : bus_csw ? pif.current_status_word
      : bus_ssw ? pif.saved_status_word_cur
      : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_r <= 32'h0000_0000;
      end else begin
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   assign reg_rdata = reg_rdata_r;

   // checks on banking, visibility, conditions, port reads, entry and reset
   a_fiq_bank: assert property (@(posedge clk) disable iff (sys_rst)
      mode == bnkrf_pkg::MODE_FIQ && rw_ok && rw_addr == 4'h8
      |=> gpr_r[5'h10] == $past(rw_data))
      else $error("fast mode r8 not banked");
   a_svc_shared: assert property (@(posedge clk) disable iff (sys_rst)
      mode == bnkrf_pkg::MODE_SVC && ra_addr == 4'hC |-> ra_phys == 5'h0C)
      else $error("supervisor r12 not shared");
   a_irq_lr: assert property (@(posedge clk) disable iff (sys_rst)
      mode == bnkrf_pkg::MODE_IRQ && rb_addr == 4'hE |-> rb_phys == 5'h18)
      else $error("normal interrupt lr not banked");
   a_user_flat: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == bnkrf_pkg::MODE_USR || mode == bnkrf_pkg::MODE_SYS)
      |-> ra_phys == {1'b0, ra_addr} && !pif.saved_status_word_ok)
      else $error("user or system mode banked");
   a_compact_hide: assert property (@(posedge clk) disable iff (sys_rst)
      tstate && !hi_ok && ra_addr == 4'h9 |-> ra_data == 32'h0000_0000 && access_err)
      else $error("hidden high register visible");
   a_cond_compact: assert property (@(posedge clk) disable iff (sys_rst)
      tstate && !is_branch |-> cond_ok)
      else $error("compact op conditioned");
   a_reset_state: assert property (@(posedge clk)
      $fell(sys_rst) |-> cur_mode == bnkrf_pkg::MODE_SVC && irq_mask && fiq_mask
      && !state_indicator_out)
      else $error("bad state after reset");
   a_read_next: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && bus_csw |=> reg_rdata == $past(pif.current_status_word))
      else $error("status read wrong");
   a_entry_mode: assert property (@(posedge clk) disable iff (sys_rst)
      exc_taken |=> cur_mode == $past(exc_mode) && !state_indicator_out)
      else $error("entry did not switch mode");
endmodule : bnkrf_top

// >>> verification/bnkrf_exc_src.sv
// exception request source standing in for the core's request logic
// assumes one clk shared with the register file and a synchronous reset
module bnkrf_exc_src (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [5:0] bits,
   input wire logic exc_taken,
   output logic [5:0] exc_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // hold the request level until it is taken or withdrawn
   always @(posedge clk) begin
      if (sys_rst) begin
         exc_req <= 6'h00;
      end else if (go) begin
         exc_req <= bits;
      end else if (exc_taken) begin
         exc_req <= 6'h00; // one entry serves the whole set
      end
   end
endmodule : bnkrf_exc_src

// >>> verification/tb_banked_regs_status_word.sv
// self-checking bench for the banked register file top
// assumes bnkrf_pkg, the status carrier and both design modules are compiled first
module tb_banked_regs_status_word;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, rw_data = 32'h0, msr_data = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rw_en = 1'b0, hi_ok = 1'b0;
   logic [3:0] ra_addr = 4'h0, rb_addr = 4'h0, rw_addr = 4'h0;
   logic [3:0] flag_val = 4'h0, msr_mask = 4'h0, cond = 4'h0;
   logic flag_we = 1'b0, q_set = 1'b0, status_write_op = 1'b0, msr_saved_status_word = 1'b0;
   logic exc_ret = 1'b0, t_we = 1'b0, t_val = 1'b0, is_branch = 1'b0;
   logic go = 1'b0;
   logic [5:0] bits = 6'h00;
   wire logic [5:0] exc_req;
   wire logic [31:0] reg_rdata, ra_data, rb_data, pc_out, csw_out, ssw_out;
   wire logic access_err, cond_ok, exc_taken, irq_mask, fiq_mask, state_indicator_out;
   wire logic [4:0] exc_mode, cur_mode;
   int n_checks = 0;
   int n_mismatch = 0;
   // core clock, 8 ns period
   always #4 clk = ~clk;
   bnkrf_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ra_addr(ra_addr),
      .ra_data(ra_data), .rb_addr(rb_addr), .rb_data(rb_data), .rw_en(rw_en),
      .rw_addr(rw_addr), .rw_data(rw_data), .hi_ok(hi_ok), .access_err(access_err),
      .pc_out(pc_out), .flag_we(flag_we), .flag_val(flag_val), .q_set(q_set),
      .status_write_op(status_write_op), .msr_saved_status_word(msr_saved_status_word), .msr_mask(msr_mask),
      .msr_data(msr_data), .exc_req(exc_req), .exc_ret(exc_ret), .t_we(t_we),
      .t_val(t_val), .cond(cond), .is_branch(is_branch), .cond_ok(cond_ok),
      .exc_taken(exc_taken), .exc_mode(exc_mode), .cur_mode(cur_mode),
      .irq_mask(irq_mask), .fiq_mask(fiq_mask), .state_indicator_out(state_indicator_out),
      .csw_out(csw_out), .ssw_out(ssw_out));
   bnkrf_exc_src u_src (.clk(clk), .sys_rst(sys_rst), .go(go), .bits(bits),
      .exc_taken(exc_taken), .exc_req(exc_req));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // register port: one-cycle strobes, read data in the following cycle
   task automatic bwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : bwr
   task automatic brd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : brd
   // core side register write and combinational read
   task automatic rwr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rw_en <= 1'b1;
      rw_addr <= a;
      rw_data <= d;
      @(posedge clk);
      rw_en <= 1'b0;
      #1;
   endtask : rwr
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      ra_addr <= a;
      rb_addr <= a;
      #1;
      chk(ra_data, exp);
      chk(rb_data, exp);
   endtask : rchk
   task automatic sw(input logic [3:0] m, input logic [31:0] d);
      @(posedge clk);
      status_write_op <= 1'b1;
      msr_mask <= m;
      msr_data <= d;
      @(posedge clk);
      status_write_op <= 1'b0;
      #1;
   endtask : sw
   task automatic exc(input logic [5:0] b);
      @(posedge clk);
      go <= 1'b1;
      bits <= b;
      @(posedge clk);
      go <= 1'b0;
      #1;
   endtask : exc
   task automatic cnd(input logic [3:0] c, input logic br, input logic exp);
      @(posedge clk);
      cond <= c;
      is_branch <= br;
      #1;
      chk(cond_ok, exp);
   endtask : cnd
   task automatic t_reset;
      chk(csw_out, 32'h0000_00D3);
      chk({irq_mask, fiq_mask, state_indicator_out}, 3'h6);
      brd(8'h00, 32'h0000_00D3);
      @(posedge clk);
      #1;
      chk(reg_rdata, 32'h0);
      brd(8'h08, 32'h0);
      $display("test reset done");
   endtask : t_reset
   // every mode but user writes r13, r8 and its saved word, then all seven read them back
   task automatic t_bank;
      logic [4:0] md [7];
      logic [31:0] e13, e8, es;
      md = '{bnkrf_pkg::MODE_FIQ, bnkrf_pkg::MODE_IRQ, bnkrf_pkg::MODE_SVC,
         bnkrf_pkg::MODE_ABT, bnkrf_pkg::MODE_UND, bnkrf_pkg::MODE_SYS, bnkrf_pkg::MODE_USR};
      for (int i = 0; i < 7; i++) begin
         // last pass fills the shared set from system mode: user mode could not leave
         bwr(8'h00, {24'h0, 3'h6, (i == 6) ? bnkrf_pkg::MODE_SYS : md[i]});
         rwr(4'hD, 32'h100 + i);
         rwr(4'h8, 32'h200 + i);
         bwr(8'h04, 32'h0F00_0300 + i);
      end
      for (int i = 0; i < 7; i++) begin
         e13 = (i >= 5) ? 32'h106 : 32'h100 + i;
         e8 = (i == 0) ? 32'h200 : 32'h206;
         es = (i >= 5) ? 32'h0 : 32'h0F00_0300 + i;
         bwr(8'h00, {24'h0, 3'h6, md[i]});
         chk(cur_mode, md[i]);
         rchk(4'hD, e13);
         rchk(4'h8, e8);
         chk(ssw_out, es);
         brd(8'h04, es);
      end
      $display("test banking done");
   endtask : t_bank
   // user mode cannot touch control bits; a software interrupt gets out
   task automatic t_user;
      int k;
      sw(4'h9, 32'hF000_0013);
      chk(csw_out, 32'hF000_00D0);
      bwr(8'h00, 32'hF000_0013);
      chk(cur_mode, bnkrf_pkg::MODE_USR);
      exc(6'h20);
      k = 0;
      while (exc_taken !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 8) begin
         n_mismatch++;
         stop_test;
      end
      chk(exc_mode, bnkrf_pkg::MODE_SVC);
      @(posedge clk);
      #1;
      chk(cur_mode, bnkrf_pkg::MODE_SVC);
      chk(ssw_out, 32'hF000_00D0);
      $display("test user done");
   endtask : t_user
   // simultaneous requests and masking
   task automatic t_prio;
      logic [7:0] c [9];
      logic [5:0] b [9];
      logic [4:0] m [9];
      logic tk [9];
      c = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'h13, 8'hD3, 8'h93, 8'h53};
      b = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h30, 6'h20, 6'h06, 6'h06, 6'h06};
      m = '{5'h17, 5'h11, 5'h12, 5'h17, 5'h1B, 5'h13, 5'h13, 5'h11, 5'h12};
      tk = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 9; i++) begin
         bwr(8'h00, {24'h0, c[i]});
         exc(b[i]);
         chk(exc_taken, tk[i]);
         if (tk[i]) chk(exc_mode, m[i]);
         @(posedge clk);
         #1;
         chk(cur_mode, m[i]);
         if (tk[i]) chk(ssw_out, {24'h0, c[i]});
         else exc(6'h00);
      end
      $display("test priority done");
   endtask : t_prio
   // flags, sticky saturation, state bit and compact register reach
   task automatic t_flags;
      bwr(8'h00, 32'h13);
      @(posedge clk);
      q_set <= 1'b1;
      @(posedge clk);
      q_set <= 1'b0;
      flag_we <= 1'b1;
      flag_val <= 4'h4;
      @(posedge clk);
      flag_we <= 1'b0;
      #1;
      chk(csw_out[31:24], 8'h48);
      cnd(4'h0, 1'b0, 1'b1);
      cnd(4'h1, 1'b0, 1'b0);
      sw(4'h8, 32'h4000_0000);
      chk(csw_out[31:24], 8'h40);
      @(posedge clk);
      t_we <= 1'b1;
      t_val <= 1'b1;
      @(posedge clk);
      t_we <= 1'b0;
      #1;
      chk({state_indicator_out, csw_out[5]}, 2'h3);
      cnd(4'h1, 1'b0, 1'b1);
      cnd(4'h1, 1'b1, 1'b0);
      rchk(4'hD, 32'h102);
      chk(access_err, 1'b0);
      rwr(4'h8, 32'h777);
      rchk(4'h8, 32'h0);
      chk(access_err, 1'b1);
      @(posedge clk);
      hi_ok <= 1'b1;
      rchk(4'h8, 32'h206);
      rwr(4'h8, 32'h888);
      rchk(4'h8, 32'h888);
      // pc stays reachable in compact state
      rwr(4'hF, 32'h0000_0400);
      chk(pc_out, 32'h0000_0400);
      // core write of the saved word, then a return restores it
      @(posedge clk);
      msr_saved_status_word <= 1'b1;
      status_write_op <= 1'b1;
      msr_mask <= 4'h1;
      msr_data <= 32'h0000_0093;
      @(posedge clk);
      status_write_op <= 1'b0;
      msr_saved_status_word <= 1'b0;
      exc_ret <= 1'b1;
      @(posedge clk);
      exc_ret <= 1'b0;
      #1;
      chk(csw_out, 32'h0000_0093);
      chk(state_indicator_out, 1'b0);
      $display("test flags done");
   endtask : t_flags
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      t_reset();
      t_bank();
      t_user();
      t_prio();
      t_flags();
      stop_test();
   end
endmodule : tb_banked_regs_status_word
